/* rhpdb_pkg.sv */
// Constants for the second root-hub descriptor register: command codes,
// field positions and reset defaults.
// Assumes one processor command per clock, on the controller clock.
package rhpdb_pkg;

    // --------------------------------------------------------------
    // Command port
    // --------------------------------------------------------------
    localparam int         CODE_W    = 8;
    localparam int         DATA_W    = 32;
    localparam logic [7:0] CMD_READ  = 8'h13;
    localparam logic [7:0] CMD_WRITE = 8'h93;

    // --------------------------------------------------------------
    // Field layout
    // --------------------------------------------------------------
    localparam int          NUM_PORTS   = 2;
    localparam int          MASK_LSB    = 16;
    localparam int          MASK_MSB    = 18;
    localparam int          FIXED_LSB   = 0;
    localparam int          FIXED_MSB   = 2;
    localparam logic [31:0] LIVE_BITS   = 32'h0006_0006;

    // --------------------------------------------------------------
    // Reset defaults, overridable per board
    // --------------------------------------------------------------
    localparam logic [2:0]  MASK_RESET  = 3'h0;
    localparam logic [2:0]  FIXED_RESET = 3'h0;

endpackage

/* rhpdb_reg_if.sv */
// Carrier between the command decoder and the register storage.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface rhpdb_reg_if;
    logic                           wr_stb;
    logic [rhpdb_pkg::DATA_W-1:0]   wdata;
    logic [rhpdb_pkg::NUM_PORTS:1]  mask;
    logic [rhpdb_pkg::NUM_PORTS:1]  fixed;
    logic [rhpdb_pkg::DATA_W-1:0]   image;

    modport bank (input wr_stb, input wdata, output mask, output fixed, output image);
    modport ctrl (output wr_stb, output wdata, input mask, input fixed, input image);
endinterface

/* rhpdb_bank.sv */
// Storage of the port power mask and fixed-device flags, with the read image.
// Assumes the write strobe is one cycle long and comes from the same clock.
`timescale 1ns/10ps
module rhpdb_bank
    import rhpdb_pkg::*;
#(
    parameter logic [2:0] MASK_INIT  = rhpdb_pkg::MASK_RESET,
    parameter logic [2:0] FIXED_INIT = rhpdb_pkg::FIXED_RESET
)
(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    // Register carrier
    rhpdb_reg_if.bank  reg_if
);

    logic [NUM_PORTS:1] port_power_mask_ff;
    logic [NUM_PORTS:1] device_fixed_flags_ff;

    // --------------------------------------------------------------
    // Storage; only port bits are kept, bit 0 of each field has no flop
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            port_power_mask_ff    <= MASK_INIT[NUM_PORTS:1];
            device_fixed_flags_ff <= FIXED_INIT[NUM_PORTS:1];
        end
        else if (reg_if.wr_stb)
        begin
            port_power_mask_ff    <= reg_if.wdata[MASK_MSB:MASK_LSB+1];
            device_fixed_flags_ff <= reg_if.wdata[FIXED_MSB:FIXED_LSB+1];
        end
    end

    assign reg_if.mask  = port_power_mask_ff;
    assign reg_if.fixed = device_fixed_flags_ff;

    // Reserved and bit-0 positions are hard zeros
    assign reg_if.image = {13'h0000, port_power_mask_ff, 1'b0,
                           13'h0000, device_fixed_flags_ff, 1'b0};

endmodule

/* rhpdb_top.sv */
// Root-hub descriptor B: command decode, register bank and port power control.
// Assumes commands and power requests come from logic on clk_i, one cycle each.
`timescale 1ns/10ps
module rhpdb_top
    import rhpdb_pkg::*;
#(
    parameter logic [2:0] MASK_INIT  = rhpdb_pkg::MASK_RESET,
    parameter logic [2:0] FIXED_INIT = rhpdb_pkg::FIXED_RESET
)
(
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             resetn_i,
    // Processor command port
    input  wire logic                             cmd_valid_i,
    input  wire logic [rhpdb_pkg::CODE_W-1:0]     cmd_code_i,
    input  wire logic [rhpdb_pkg::DATA_W-1:0]     cmd_wdata_i,
    output logic      [rhpdb_pkg::DATA_W-1:0]     rd_data_o,
    output logic                                  rd_valid_o,
    output logic                                  wr_done_o,
    // Switching configuration from descriptor A
    input  wire logic                             ports_always_on_i,
    input  wire logic                             per_port_switch_select_bit_i,
    // Power commands
    input  wire logic                             all_ports_on_command_i,
    input  wire logic                             all_ports_off_command_i,
    input  wire logic [rhpdb_pkg::NUM_PORTS:1]    single_port_power_command_on_i,
    input  wire logic [rhpdb_pkg::NUM_PORTS:1]    single_port_power_command_off_i,
    // Port state
    output logic      [rhpdb_pkg::NUM_PORTS:1]    port_powered_state_o,
    output logic      [rhpdb_pkg::NUM_PORTS:1]    port_power_mask_o,
    output logic      [rhpdb_pkg::NUM_PORTS:1]    device_fixed_flags_o
);

    import rhpdb_pkg::*;

    // --------------------------------------------------------------
    // Command decode
    // --------------------------------------------------------------
    rhpdb_reg_if reg_if ();

    wire read_hit  = cmd_valid_i && (cmd_code_i == CMD_READ);
    wire write_hit = cmd_valid_i && (cmd_code_i == CMD_WRITE);

    assign reg_if.wr_stb = write_hit;
    assign reg_if.wdata  = cmd_wdata_i;

    rhpdb_bank #(
        .MASK_INIT  (MASK_INIT),
        .FIXED_INIT (FIXED_INIT)
    ) u_bank (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .reg_if   (reg_if)
    );

    // --------------------------------------------------------------
    // Read answer; other codes belong to other registers and are ignored
    // --------------------------------------------------------------
    logic [DATA_W-1:0] rd_data_ff;
    logic              rd_valid_ff;
    logic              wr_done_ff;
    wire  [DATA_W-1:0] nxt_rd_data = read_hit ? reg_if.image : rd_data_ff;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_data_ff  <= 32'h0000_0000;
            rd_valid_ff <= 1'b0;
            wr_done_ff  <= 1'b0;
        end
        else
        begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= read_hit;
            wr_done_ff  <= write_hit;
        end
    end

    assign rd_data_o            = rd_data_ff;
    assign rd_valid_o           = rd_valid_ff;
    assign wr_done_o            = wr_done_ff;
    assign port_power_mask_o    = reg_if.mask;
    assign device_fixed_flags_o = reg_if.fixed;

    // --------------------------------------------------------------
    // Port power control
    // --------------------------------------------------------------
    // An off request beats an on request in the same cycle: a port
    // left unpowered is the safe outcome of a conflicting command.
    logic [NUM_PORTS:1] port_powered_ff;
    logic [NUM_PORTS:1] nxt_port_powered;
    logic [NUM_PORTS:1] follow_single;
    logic [NUM_PORTS:1] take_on;
    logic [NUM_PORTS:1] take_off;

    for (genvar p = 1; p <= NUM_PORTS; p++)
    begin : g_port
        // Mask only matters in per-port mode
        assign follow_single[p] = per_port_switch_select_bit_i && reg_if.mask[p];
        assign take_on[p]  = follow_single[p] ? single_port_power_command_on_i[p]
                                              : all_ports_on_command_i;
        assign take_off[p] = follow_single[p] ? single_port_power_command_off_i[p]
                                              : all_ports_off_command_i;
        assign nxt_port_powered[p] = ports_always_on_i ? 1'b1 :
                                     take_off[p]       ? 1'b0 :
                                     take_on[p]        ? 1'b1 : port_powered_ff[p];
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            port_powered_ff <= 2'h0;
        else
            port_powered_ff <= nxt_port_powered;
    end

    assign port_powered_state_o = port_powered_ff;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_read_returns_image: assert property (@(posedge clk_i) disable iff (!resetn_i)
        read_hit |=> rd_valid_o && (rd_data_o == $past(reg_if.image)))
        else $error("read command did not return the register image");

    a_write_then_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
        write_hit ##1 read_hit |=>
            rd_data_o[MASK_MSB:MASK_LSB+1] == $past(cmd_wdata_i[MASK_MSB:MASK_LSB+1], 2))
        else $error("mask written was not read back");

    a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rd_valid_o |-> ((rd_data_o & ~LIVE_BITS) == 32'h0000_0000))
        else $error("reserved bit read as one");

    a_mask_port_map: assert property (@(posedge clk_i) disable iff (!resetn_i)
        write_hit |=> port_power_mask_o == $past(cmd_wdata_i[MASK_MSB:MASK_LSB+1]))
        else $error("mask bits not mapped to ports 1 and 2");

    a_fixed_port_map: assert property (@(posedge clk_i) disable iff (!resetn_i)
        write_hit |=> device_fixed_flags_o == $past(cmd_wdata_i[FIXED_MSB:FIXED_LSB+1]))
        else $error("fixed-device bits not mapped to ports 1 and 2");

    a_other_code_ignored: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !write_hit [*2] |-> $stable(port_power_mask_o) && $stable(device_fixed_flags_o))
        else $error("fields changed without a write command");

    a_masked_ignores_all: assert property (@(posedge clk_i) disable iff (!resetn_i)
        per_port_switch_select_bit_i && reg_if.mask[1] && !ports_always_on_i
            && !single_port_power_command_on_i[1] && !single_port_power_command_off_i[1]
            |=> $stable(port_powered_state_o[1]))
        else $error("masked port moved on an all-ports command");

    a_single_port_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        per_port_switch_select_bit_i && reg_if.mask[2] && !ports_always_on_i
            && single_port_power_command_off_i[2] |=> !port_powered_state_o[2])
        else $error("single-port off did not remove power");

    a_unmasked_ignores_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !reg_if.mask[2] && !ports_always_on_i && !all_ports_on_command_i && !all_ports_off_command_i
            |=> $stable(port_powered_state_o[2]))
        else $error("unmasked port moved on a single-port command");

    a_global_mode_all_on: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !per_port_switch_select_bit_i && all_ports_on_command_i && !all_ports_off_command_i
            |=> port_powered_state_o == 2'h3)
        else $error("global on left a port unpowered");

    a_perport_global_on: assert property (@(posedge clk_i) disable iff (!resetn_i)
        per_port_switch_select_bit_i && all_ports_on_command_i && !all_ports_off_command_i
            && reg_if.mask[1] && !ports_always_on_i && !single_port_power_command_on_i[1]
            && !single_port_power_command_off_i[1]
            |=> port_powered_state_o[1] == $past(port_powered_state_o[1]))
        else $error("global on powered a masked port");

    a_always_on_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ports_always_on_i [*2] |-> port_powered_state_o == 2'h3)
        else $error("always-on configuration left a port off");

endmodule

/* rhpdb_tb.sv */
// Self-checking bench for the root-hub port power and removable-device register.
// Assumes the design is built with non-zero reset defaults so that they show on the first read.
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module testbench;
    import rhpdb_pkg::*;

    // --------------------------------------------------------------
    // Signals and notes
    // --------------------------------------------------------------
    typedef struct { logic [1:0] kind; logic [31:0] value; } rhpdb_note_type;
    localparam logic [2:0] M_INIT = 3'h4;
    localparam logic [2:0] F_INIT = 3'h2;
    logic        clk_i, resetn_i, cmd_valid_i, on_i, sel_i, all_on_i, all_off_i, pwr_chk;
    logic [7:0]  cmd_code_i;
    logic [31:0] cmd_wdata_i, rd_data_o, lfsr, d;
    logic        rd_valid_o, wr_done_o;
    logic [2:1]  son_i, soff_i, state_o, mask_o, fixed_o;
    logic [1:0]  ev;
    int          failures, checked, i;
    rhpdb_note_type notes[$];
    rhpdb_note_type n;

    rhpdb_top #(.MASK_INIT(M_INIT), .FIXED_INIT(F_INIT)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .cmd_wdata_i(cmd_wdata_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .wr_done_o(wr_done_o), .ports_always_on_i(on_i), .per_port_switch_select_bit_i(sel_i),
        .all_ports_on_command_i(all_on_i), .all_ports_off_command_i(all_off_i),
        .single_port_power_command_on_i(son_i), .single_port_power_command_off_i(soff_i),
        .port_powered_state_o(state_o), .port_power_mask_o(mask_o), .device_fixed_flags_o(fixed_o));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0020_0003 : 32'h0000_0000);
    endfunction

    // --------------------------------------------------------------
    // Drivers: one command or power request per falling edge
    // --------------------------------------------------------------
    task automatic issue(input logic [7:0] code, input logic [31:0] wd, input logic [1:0] k,
                         input logic [31:0] exp);
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_code_i  = code;
        cmd_wdata_i = wd;
        pwr_chk     = 1'b0;
        if (k != 2'd3) notes.push_back('{k, exp});
    endtask

    task automatic pwr(input logic ao, input logic af, input logic [2:1] sn, input logic [2:1] sf,
                       input logic [2:1] exp);
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
        all_on_i    = ao;
        all_off_i   = af;
        son_i       = sn;
        soff_i      = sf;
        pwr_chk     = 1'b1;
        notes.push_back('{2'd2, {30'h0, exp}});
    endtask

    // Mode change in a cycle of its own, with every request idle
    task automatic mode(input logic ps, input logic aon);
        @(negedge clk_i);
        {cmd_valid_i, all_on_i, all_off_i, son_i, soff_i, pwr_chk} = 8'h00;
        sel_i = ps;
        on_i  = aon;
    endtask

    // --------------------------------------------------------------
    // Monitor: each answer takes the oldest note
    // --------------------------------------------------------------
    always
    begin
        @(posedge clk_i);
        #1;
        if (rd_valid_o === 1'b1 || wr_done_o === 1'b1 || pwr_chk)
        begin
            ev = (rd_valid_o === 1'b1) ? 2'd0 : (wr_done_o === 1'b1) ? 2'd1 : 2'd2;
            if (notes.size() == 0)
            begin
                failures++;
                $display("[ERR] %0t answer with nothing expected", $time);
            end
            else
            begin
                n = notes.pop_front();
                `CHK(ev, n.kind)
                if (ev == 2'd0) `CHK(rd_data_o, n.value)
                if (ev == 2'd1) `CHK({mask_o, fixed_o}, n.value[3:0])
                if (ev == 2'd2) `CHK(state_o, n.value[1:0])
            end
        end
    end

    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        {resetn_i, cmd_valid_i, on_i, sel_i, all_on_i, all_off_i, pwr_chk} = 7'h00;
        {cmd_code_i, cmd_wdata_i, son_i, soff_i} = 44'h0;
        lfsr = 32'ha30b_a028;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        resetn_i = 1'b1;
        // Reset defaults come from the build, reserved bits stay clear
        issue(CMD_READ, 32'h0, 2'd0, {13'h0, M_INIT[2:1], 1'b0, 13'h0, F_INIT[2:1], 1'b0});
        issue(CMD_WRITE, 32'hffff_ffff, 2'd1, 32'h0000_000f);
        issue(CMD_READ, 32'h0, 2'd0, LIVE_BITS);
        for (i = 0; i < 6; i++)
        begin
            lfsr = lfsr_next(lfsr);
            d    = lfsr;
            issue(CMD_WRITE, d, 2'd1, {28'h0, d[18:17], d[2:1]});
            issue(CMD_READ, 32'h0, 2'd0, d & LIVE_BITS);
        end
        // Foreign codes leave the register alone and give no answer
        issue(8'h94, 32'h0000_0000, 2'd3, 32'h0);
        issue(8'h14, 32'h0, 2'd3, 32'h0);
        issue(CMD_READ, 32'h0, 2'd0, d & LIVE_BITS);
        issue(CMD_WRITE, 32'h0004_0000, 2'd1, 32'h0000_0008);
        // Global mode: mask ignored, single-port requests ignored
        pwr(1'b1, 1'b0, 2'b00, 2'b00, 2'b11);
        pwr(1'b0, 1'b0, 2'b00, 2'b11, 2'b11);
        pwr(1'b0, 1'b1, 2'b00, 2'b00, 2'b00);
        // Per-port mode with port 2 masked
        mode(1'b1, 1'b0);
        pwr(1'b1, 1'b0, 2'b00, 2'b00, 2'b01);
        pwr(1'b0, 1'b0, 2'b11, 2'b00, 2'b11);
        pwr(1'b0, 1'b1, 2'b00, 2'b00, 2'b10);
        pwr(1'b0, 1'b0, 2'b00, 2'b11, 2'b00);
        pwr(1'b0, 1'b0, 2'b00, 2'b00, 2'b00);
        // Per-port mode with port 1 masked
        issue(CMD_WRITE, 32'h0002_0000, 2'd1, 32'h0000_0004);
        pwr(1'b1, 1'b0, 2'b00, 2'b00, 2'b10);
        pwr(1'b0, 1'b0, 2'b11, 2'b00, 2'b11);
        pwr(1'b0, 1'b1, 2'b00, 2'b00, 2'b01);
        // Ports that cannot be switched stay on
        mode(1'b1, 1'b1);
        pwr(1'b0, 1'b1, 2'b00, 2'b11, 2'b11);
        @(negedge clk_i);
        pwr_chk = 1'b0;
        for (i = 0; i < 20 && notes.size() != 0; i++) @(negedge clk_i);
        if (notes.size() != 0)
        begin
            failures++;
            $display("[ERR] %0t answers missing", $time);
        end
        wrap_up();
    end
endmodule
